//--- rtl/eight_bit_timer_regs.vh
/*
  Register indices, field positions, reset values and prescaler
  exponents for the 8-bit timer control block.
  Assumes a Wishbone byte address that is four times the index.
*/
`ifndef EIGHT_BIT_TIMER_REGS_VH
`define EIGHT_BIT_TIMER_REGS_VH

// Register indices (byte address = index * 4)
`define EBT_IDX_COUNT0 16'hFF16
`define EBT_IDX_CMP0 16'hFF17
`define EBT_IDX_TCL0 16'hFF6A
`define EBT_IDX_TMC0 16'hFF6B
`define EBT_IDX_TCL1 16'hFF8C
`define EBT_IDX_RUN1 16'hFF8D

// Mode control field positions
`define EBT_RUN_BIT 7
`define EBT_PWM_BIT 6
`define EBT_PRESET_SET_BIT 3
`define EBT_PRESET_CLR_BIT 2
`define EBT_INV_BIT 1
`define EBT_OE_BIT 0

// Reset values
`define EBT_TCL_RESET 3'h0
`define EBT_BYTE_RESET 8'h00

// Clock select codes
`define EBT_SEL_FALLING 3'h0
`define EBT_SEL_RISING 3'h1
`define EBT_SEL_DIV_CODE2 3'h2
`define EBT_SEL_DIV_CODE3 3'h3
`define EBT_SEL_DIV_CODE4 3'h4
`define EBT_SEL_DIV_CODE5 3'h5
`define EBT_SEL_DIV_CODE6 3'h6

// Divide exponents (divide by two to the exponent)
`define EBT_EXP_CODE2 4'h0
`define EBT_EXP_CODE3 4'h1
`define EBT_EXP_CODE5 4'h6
`define EBT_EXP_CODE6 4'h8
`define EBT_T0_EXP_CODE4 4'h2
`define EBT_T0_EXP_CODE7 4'hD
`define EBT_T1_EXP_CODE4 4'h4
`define EBT_T1_EXP_CODE7 4'hC
`define EBT_DIV_WIDTH 13

`endif

//--- rtl/count_source_select.v
/*
  Count source for one 8-bit timer: event pin edge or divided clock.
  Assumes the event pin is asynchronous to clk_i; one tick per count.
*/
`timescale 1ns/100ps
`include "eight_bit_timer_regs.vh"
module count_source_select #(
  parameter [3:0] EXP_CODE4 = `EBT_T0_EXP_CODE4,
  parameter [3:0] EXP_CODE7 = `EBT_T0_EXP_CODE7
) (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire [2:0] select_i,
  input wire event_pin_i,
  output wire tick_o
);

  reg sync_a_ff;
  reg sync_b_ff;
  reg prev_ff;
  reg tick_ff;
  reg [`EBT_DIV_WIDTH-1:0] div_ff;
  reg [`EBT_DIV_WIDTH-1:0] mask;
  reg nxt_tick;

  // Exponent of the divider for a clock select code
  function [3:0] div_exp;
    input [2:0] code;
    begin
      if (code == `EBT_SEL_DIV_CODE2) div_exp = `EBT_EXP_CODE2;
      else if (code == `EBT_SEL_DIV_CODE3) div_exp = `EBT_EXP_CODE3;
      else if (code == `EBT_SEL_DIV_CODE4) div_exp = EXP_CODE4;
      else if (code == `EBT_SEL_DIV_CODE5) div_exp = `EBT_EXP_CODE5;
      else if (code == `EBT_SEL_DIV_CODE6) div_exp = `EBT_EXP_CODE6;
      else div_exp = EXP_CODE7;
    end
  endfunction

  // Low bits all ones marks the end of one divided period
  function [`EBT_DIV_WIDTH-1:0] low_mask;
    input [3:0] e;
    integer i;
    begin
      for (i = 0; i < `EBT_DIV_WIDTH; i = i + 1) begin
        low_mask[i] = (i < e);
      end
    end
  endfunction

  always @* begin
    mask = low_mask(div_exp(select_i));
    nxt_tick = 1'b0;
    if (run_i) begin
      if (select_i == `EBT_SEL_FALLING) begin
        nxt_tick = prev_ff & ~sync_b_ff;
      end else if (select_i == `EBT_SEL_RISING) begin
        nxt_tick = sync_b_ff & ~prev_ff;
      end else begin
        nxt_tick = ((div_ff & mask) == mask);
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_a_ff <= 1'b0;
      sync_b_ff <= 1'b0;
      prev_ff <= 1'b0;
      tick_ff <= 1'b0;
      div_ff <= {`EBT_DIV_WIDTH{1'b0}};
    end else begin
      sync_a_ff <= event_pin_i;
      sync_b_ff <= sync_a_ff;
      prev_ff <= sync_b_ff;
      tick_ff <= nxt_tick;
      if (run_i) begin
        div_ff <= div_ff + {{(`EBT_DIV_WIDTH-1){1'b0}}, 1'b1};
      end else begin
        div_ff <= {`EBT_DIV_WIDTH{1'b0}};
      end
    end
  end

  assign tick_o = tick_ff;

endmodule

//--- rtl/eight_bit_timer_control.v
/*
  Control logic for two 8-bit timer/event counters on classic Wishbone:
  clock select, run control, clear-on-match or PWM mode, output
  flip-flop preset, inversion or polarity, and output enable.
  Assumes a synchronous active-high reset and one 100 MHz clock.
  Assumes byte addresses four times the register index, byte lane 0.
  Assumes asynchronous event pins, resynchronised inside the sources.
  The output pin follows mode bits in the edge that writes them.
*/
`timescale 1ns/100ps
`include "eight_bit_timer_regs.vh"
module eight_bit_timer_control (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [17:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  input wire event_input_pin_0_i,
  input wire event_input_pin_1_i,
  output wire timer_output_pin_0_o,
  output wire match_interrupt_o,
  output wire count_tick_1_o
);

  // Bus state
  reg ack_ff;
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;

  // Software state
  reg [2:0] timer_clock_select_0_ff;
  reg [2:0] timer_clock_select_1_ff;
  reg count_run_bit_ff;
  reg pwm_mode_select_ff;
  reg invert_or_polarity_bit_ff;
  reg output_enable_bit_ff;
  reg [7:0] compare_value_0_ff;
  reg run_1_ff;
  reg nxt_count_run;
  reg nxt_pwm_mode;
  reg nxt_invert;
  reg nxt_output_enable;

  // Timer state
  reg [7:0] up_counter_0_ff;
  reg [7:0] nxt_up_counter_0;
  reg out_flipflop_ff;
  reg nxt_out_flipflop;
  reg pwm_active_ff;
  reg nxt_pwm_active;
  reg match_irq_ff;
  reg nxt_match_irq;
  reg pin_ff;
  reg nxt_pin;

  wire req;
  wire wr_fire;
  wire wr_tcl0;
  wire wr_tcl1;
  wire wr_tmc0;
  wire wr_cmp0;
  wire wr_run1;
  wire flipflop_preset_set;
  wire flipflop_preset_clear;
  wire tick0;
  wire tick1;
  wire counter_match;
  wire counter_top;

  // Word index match on the byte address
  function hit;
    input [17:0] adr;
    input [15:0] idx;
    begin
      hit = (adr[17:2] == idx);
    end
  endfunction

  // Preset strobe from a written byte, 11 selects neither
  function preset_strobe;
    input [7:0] data;
    input want_set;
    begin
      if (want_set) begin
        preset_strobe = data[`EBT_PRESET_SET_BIT] &
          ~data[`EBT_PRESET_CLR_BIT];
      end else begin
        preset_strobe = data[`EBT_PRESET_CLR_BIT] &
          ~data[`EBT_PRESET_SET_BIT];
      end
    end
  endfunction

  // Mode byte as read back, preset strobes always read zero
  function [7:0] mode_readback;
    input run;
    input pwm;
    input inv;
    input oe;
    begin
      mode_readback = {run, pwm, 2'h0, 2'h0, inv, oe};
    end
  endfunction

  // Pin level: low when disabled, PWM level with polarity, or flip-flop
  function pin_level;
    input oe;
    input pwm;
    input inv;
    input active;
    input ff;
    begin
      pin_level = 1'h0;
      if (oe) begin
        if (pwm) begin
          pin_level = active ^ inv;
        end else begin
          pin_level = ff;
        end
      end
    end
  endfunction

  // Wishbone slave: ack one cycle after the request, write at ack edge
  assign req = cyc_i & stb_i;
  assign wr_fire = req & we_i & ack_ff & sel_i[0];
  assign wr_tcl0 = wr_fire & hit(adr_i, `EBT_IDX_TCL0);
  assign wr_tcl1 = wr_fire & hit(adr_i, `EBT_IDX_TCL1);
  assign wr_tmc0 = wr_fire & hit(adr_i, `EBT_IDX_TMC0);
  assign wr_cmp0 = wr_fire & hit(adr_i, `EBT_IDX_CMP0);
  assign wr_run1 = wr_fire & hit(adr_i, `EBT_IDX_RUN1);

  // Preset strobes, acting only outside PWM mode
  assign flipflop_preset_set = wr_tmc0 & ~pwm_mode_select_ff &
    preset_strobe(dat_i[7:0], 1'h1);
  assign flipflop_preset_clear = wr_tmc0 & ~pwm_mode_select_ff &
    preset_strobe(dat_i[7:0], 1'h0);

  // Read data mux, unmapped reads return zero
  always @* begin
    nxt_rdata = `EBT_BYTE_RESET;
    if (hit(adr_i, `EBT_IDX_TCL0)) begin
      nxt_rdata = {5'h00, timer_clock_select_0_ff};
    end else if (hit(adr_i, `EBT_IDX_TCL1)) begin
      nxt_rdata = {5'h00, timer_clock_select_1_ff};
    end else if (hit(adr_i, `EBT_IDX_TMC0)) begin
      nxt_rdata = mode_readback(count_run_bit_ff, pwm_mode_select_ff,
        invert_or_polarity_bit_ff, output_enable_bit_ff);
    end else if (hit(adr_i, `EBT_IDX_CMP0)) begin
      nxt_rdata = compare_value_0_ff;
    end else if (hit(adr_i, `EBT_IDX_COUNT0)) begin
      nxt_rdata = up_counter_0_ff;
    end else if (hit(adr_i, `EBT_IDX_RUN1)) begin
      nxt_rdata = {7'h00, run_1_ff};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= `EBT_BYTE_RESET;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (req & ~ack_ff) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = {24'h000000, rdata_ff};

  // Clock select registers, only the three select bits are kept
  always @(posedge clk_i) begin
    if (rst_i) begin
      timer_clock_select_0_ff <= `EBT_TCL_RESET;
      timer_clock_select_1_ff <= `EBT_TCL_RESET;
    end else begin
      if (wr_tcl0) begin
        timer_clock_select_0_ff <= dat_i[2:0];
      end
      if (wr_tcl1) begin
        timer_clock_select_1_ff <= dat_i[2:0];
      end
    end
  end

  // Next mode bits, the stored value unless software writes them
  always @* begin
    nxt_count_run = count_run_bit_ff;
    nxt_pwm_mode = pwm_mode_select_ff;
    nxt_invert = invert_or_polarity_bit_ff;
    nxt_output_enable = output_enable_bit_ff;
    if (wr_tmc0) begin
      nxt_count_run = dat_i[`EBT_RUN_BIT];
      nxt_pwm_mode = dat_i[`EBT_PWM_BIT];
      nxt_invert = dat_i[`EBT_INV_BIT];
      nxt_output_enable = dat_i[`EBT_OE_BIT];
    end
  end

  // Mode control register, preset bits are not stored
  always @(posedge clk_i) begin
    if (rst_i) begin
      count_run_bit_ff <= 1'b0;
      pwm_mode_select_ff <= 1'b0;
      invert_or_polarity_bit_ff <= 1'b0;
      output_enable_bit_ff <= 1'b0;
    end else begin
      count_run_bit_ff <= nxt_count_run;
      pwm_mode_select_ff <= nxt_pwm_mode;
      invert_or_polarity_bit_ff <= nxt_invert;
      output_enable_bit_ff <= nxt_output_enable;
    end
  end

  // Compare value and timer 1 run control
  always @(posedge clk_i) begin
    if (rst_i) begin
      compare_value_0_ff <= `EBT_BYTE_RESET;
      run_1_ff <= 1'b0;
    end else begin
      if (wr_cmp0) begin
        compare_value_0_ff <= dat_i[7:0];
      end
      if (wr_run1) begin
        run_1_ff <= dat_i[0];
      end
    end
  end

  // Count sources for both timers
  count_source_select #(
    .EXP_CODE4(`EBT_T0_EXP_CODE4),
    .EXP_CODE7(`EBT_T0_EXP_CODE7)
  ) source_0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(count_run_bit_ff),
    .select_i(timer_clock_select_0_ff),
    .event_pin_i(event_input_pin_0_i),
    .tick_o(tick0)
  );

  count_source_select #(
    .EXP_CODE4(`EBT_T1_EXP_CODE4),
    .EXP_CODE7(`EBT_T1_EXP_CODE7)
  ) source_1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run_1_ff),
    .select_i(timer_clock_select_1_ff),
    .event_pin_i(event_input_pin_1_i),
    .tick_o(tick1)
  );

  assign count_tick_1_o = tick1;

  assign counter_match = (up_counter_0_ff == compare_value_0_ff);
  assign counter_top = (up_counter_0_ff == 8'hFF);

  // Counter, output flip-flop, PWM level and match event
  always @* begin
    nxt_up_counter_0 = up_counter_0_ff;
    nxt_out_flipflop = out_flipflop_ff;
    nxt_pwm_active = pwm_active_ff;
    nxt_match_irq = 1'b0;
    if (!count_run_bit_ff) begin
      nxt_up_counter_0 = `EBT_BYTE_RESET;
      nxt_pwm_active = 1'b0;
    end else if (tick0) begin
      if (pwm_mode_select_ff) begin
        nxt_up_counter_0 = up_counter_0_ff + 8'h01;
        if (counter_match) begin
          nxt_pwm_active = 1'b0;
        end else if (counter_top) begin
          nxt_pwm_active = 1'b1;
        end
      end else if (counter_match) begin
        nxt_up_counter_0 = `EBT_BYTE_RESET;
        nxt_match_irq = 1'b1;
        if (invert_or_polarity_bit_ff) begin
          nxt_out_flipflop = ~out_flipflop_ff;
        end
      end else begin
        nxt_up_counter_0 = up_counter_0_ff + 8'h01;
      end
    end
    if (flipflop_preset_clear) begin
      nxt_out_flipflop = 1'b0;
    end else if (flipflop_preset_set) begin
      nxt_out_flipflop = 1'b1;
    end
  end

  // Pin level from the next mode, polarity and enable bits
  always @* begin
    nxt_pin = pin_level(nxt_output_enable, nxt_pwm_mode, nxt_invert,
      nxt_pwm_active, nxt_out_flipflop);
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      up_counter_0_ff <= `EBT_BYTE_RESET;
      out_flipflop_ff <= 1'b0;
      pwm_active_ff <= 1'b0;
      match_irq_ff <= 1'b0;
      pin_ff <= 1'b0;
    end else begin
      up_counter_0_ff <= nxt_up_counter_0;
      out_flipflop_ff <= nxt_out_flipflop;
      pwm_active_ff <= nxt_pwm_active;
      match_irq_ff <= nxt_match_irq;
      pin_ff <= nxt_pin;
    end
  end

  assign timer_output_pin_0_o = pin_ff;
  assign match_interrupt_o = match_irq_ff;

endmodule

//--- tb/eight_bit_timer_monitor.sv
/* Checker on the timer control ports.
   Assumes one-cycle ack and byte address four times the index. */
`timescale 1ns/100ps
module eight_bit_timer_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [17:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire event_input_pin_0_i,
  input wire event_input_pin_1_i,
  input wire timer_output_pin_0_o,
  input wire match_interrupt_o,
  input wire count_tick_1_o
);
  reg run_ff, pwm_ff, oe_ff;
  wire wr = ack_o && we_i && sel_i[0] && adr_i == 18'h3FDAC;
  wire pin = timer_output_pin_0_o;
  wire irq = match_interrupt_o;
  // Shadow of stored mode bits
  always @(posedge clk_i) begin
    if (rst_i) begin
      run_ff <= 1'h0;
      pwm_ff <= 1'h0;
      oe_ff <= 1'h0;
    end else if (wr) begin
      run_ff <= dat_i[7];
      pwm_ff <= dat_i[6];
      oe_ff <= dat_i[0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  upper_zero_a: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  preset_read_a: assert property (
    ack_o && !we_i && adr_i == 18'h3FDAC |-> dat_o[3:2] == 2'h0)
    else $error("preset bits read back");
  reset_quiet_a: assert property (disable iff (1'h0)
    rst_i |=> !pin && !irq && !ack_o) else $error("busy after reset");
  stop_quiet_a: assert property (!run_ff && !$past(run_ff) &&
    !$past(run_ff, 2) && !$past(run_ff, 3) |-> !irq)
    else $error("irq while stopped");
  pwm_quiet_a: assert property (pwm_ff && $past(pwm_ff) &&
    $past(pwm_ff, 2) && $past(pwm_ff, 3) |-> !irq)
    else $error("irq in pwm mode");
  oe_low_a: assert property (!oe_ff |-> !pin)
    else $error("pin high with output off");
  preset_clr_a: assert property (wr && dat_i[3:2] == 2'h1 &&
    !pwm_ff |=> !pin) else $error("preset clear lost");
  preset_set_a: assert property (wr && dat_i[3:2] == 2'h2 &&
    !pwm_ff && dat_i[0] |=> pin) else $error("preset set lost");
  irq_c: cover property (irq);
  tick_c: cover property (count_tick_1_o);
  pwm_high_c: cover property (pwm_ff && run_ff && pin);
endmodule
bind eight_bit_timer_control eight_bit_timer_monitor i_eight_bit_timer_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .event_input_pin_0_i(event_input_pin_0_i),
  .event_input_pin_1_i(event_input_pin_1_i),
  .timer_output_pin_0_o(timer_output_pin_0_o),
  .match_interrupt_o(match_interrupt_o), .count_tick_1_o(count_tick_1_o));

//--- tb/event_pin_source.sv
/* External pulse source driving both event pins.
   Assumes the bench calls pulse from its main process. */
`timescale 1ns/100ps
module event_pin_source (
  input wire clk_i,
  output reg [1:0] pins_o = 2'h0
);
  // Pins idle low; each level held for hold plus one cycles
  task automatic pulse(input int n, input int hold);
    repeat (2 * n) begin
      @(posedge clk_i);
      pins_o <= ~pins_o;
      repeat (hold) @(posedge clk_i);
    end
  endtask
endmodule

//--- tb/eight_bit_timer_control_tb.sv
/* Self-checking bench for the timer control block.
   Assumes one-cycle ack and byte address four times the index. */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin \
  err_count++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module eight_bit_timer_control_tb;
  localparam [17:0] CNT = 18'h3FC58, CMP = 18'h3FC5C, TCL0 = 18'h3FDA8;
  localparam [17:0] MODE = 18'h3FDAC, TCL1 = 18'h3FE30, RUN1 = 18'h3FE34;
  reg clk_i, rst_i, cyc_i, stb_i, we_i;
  reg [17:0] adr_i;
  reg [3:0] sel_i;
  logic [3:0] msk = 4'hF;
  reg [31:0] dat_i;
  wire [31:0] dat_o;
  wire [1:0] ev;
  wire ack_o, pin, irq, tick;
  logic [31:0] exp_q[$];
  logic [31:0] ex;
  logic [17:0] regs[6] = '{CNT, CMP, TCL0, MODE, TCL1, 18'h00010};
  int err_count = 0, n_checks = 0, seed = 84, ticks = 0;
  int c, n, h1, h2, q1, q2, cm;
  int e0[8] = '{0, 0, 0, 1, 2, 6, 8, 13};
  int e1[8] = '{0, 0, 0, 1, 4, 6, 8, 12};
  eight_bit_timer_control i_eight_bit_timer_control (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .event_input_pin_0_i(ev[0]), .event_input_pin_1_i(ev[1]),
    .timer_output_pin_0_o(pin), .match_interrupt_o(irq),
    .count_tick_1_o(tick));
  event_pin_source i_event_pin_source (.clk_i(clk_i), .pins_o(ev));
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  // Read data against the oldest noted value
  always @(posedge clk_i) begin
    if (tick === 1'h1)
      ticks++;
    if (ack_o === 1'h1 && we_i === 1'h0) begin
      ex = exp_q.pop_front();
      `CHK("read", ex, dat_o)
    end
  end
  task automatic await(input int s, input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while ((s == 0 ? ack_o : s == 1 ? irq : tick) !== 1'h1 && k < lim);
    if ((s == 0 ? ack_o : s == 1 ? irq : tick) !== 1'h1) begin
      err_count++;
      test_done();
    end
  endtask
  task automatic wb(input [17:0] a, input w, input [7:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    sel_i <= msk;
    adr_i <= a;
    dat_i <= {24'h0, d};
    if (!w)
      exp_q.push_back({24'h0, d});
    await(0, 50, k);
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask
  task automatic pin_chk(input e);
    repeat (2) @(posedge clk_i);
    `CHK("pin", e, pin)
  endtask
  task automatic high(output int h, output int q);
    h = 0;
    q = 0;
    repeat (256) @(posedge clk_i);
    repeat (512) begin
      @(posedge clk_i);
      h += (pin === 1'h1);
      q += (irq === 1'h1);
    end
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    rst_i = 1'h1;
    cyc_i = 1'h0;
    stb_i = 1'h0;
    we_i = 1'h0;
    sel_i = 4'h0;
    adr_i = 18'h0;
    dat_i = 32'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    foreach (regs[i])
      wb(regs[i], 1'h0, 8'h00);
    wb(18'h00010, 1'h1, 8'h5A);
    wb(18'h00010, 1'h0, 8'h00);
    wb(TCL1, 1'h1, 8'h05);
    wb(TCL1, 1'h0, 8'h05);
    msk = 4'h0;
    wb(TCL1, 1'h1, 8'h03);
    msk = 4'hF;
    wb(TCL1, 1'h0, 8'h05);
    $display("reset test done");
    wb(MODE, 1'h1, 8'h09);
    pin_chk(1'h1);
    wb(MODE, 1'h0, 8'h01);
    wb(MODE, 1'h1, 8'h08);
    pin_chk(1'h0);
    wb(MODE, 1'h1, 8'h01);
    pin_chk(1'h1);
    wb(MODE, 1'h1, 8'h05);
    pin_chk(1'h0);
    $display("preset test done");
    for (c = 2; c < 8; c++) begin
      cm = (c < 6) ? ($random(seed) & 3) : 0;
      wb(MODE, 1'h1, 8'h00);
      wb(TCL0, 1'h1, c[7:0]);
      wb(CMP, 1'h1, cm[7:0]);
      wb(MODE, 1'h1, 8'h80);
      await(1, 40000, n);
      await(1, 40000, n);
      `CHK("t0_period", (cm + 1) << e0[c], n)
      wb(RUN1, 1'h1, 8'h00);
      wb(TCL1, 1'h1, c[7:0]);
      wb(RUN1, 1'h1, 8'h01);
      await(2, 40000, n);
      await(2, 40000, n);
      `CHK("t1_period", 1 << e1[c], n)
    end
    wb(MODE, 1'h1, 8'h00);
    wb(CNT, 1'h0, 8'h00);
    $display("divider test done");
    wb(RUN1, 1'h1, 8'h00);
    wb(CMP, 1'h1, 8'hFF);
    for (c = 0; c < 2; c++) begin
      wb(TCL0, 1'h1, c[7:0]);
      wb(TCL1, 1'h1, c[7:0]);
      wb(MODE, 1'h1, 8'h80);
      wb(RUN1, 1'h1, 8'h01);
      ticks = 0;
      i_event_pin_source.pulse(3, c * 4 + 1);
      repeat (8) @(posedge clk_i);
      wb(CNT, 1'h0, 8'h03);
      `CHK("t1_events", 3, ticks)
      wb(MODE, 1'h1, 8'h00);
      wb(RUN1, 1'h1, 8'h00);
    end
    $display("event test done");
    wb(TCL0, 1'h1, 8'h02);
    wb(CMP, 1'h1, 8'h40);
    wb(MODE, 1'h1, 8'h41);
    wb(MODE, 1'h1, 8'h49);
    pin_chk(1'h0);
    wb(MODE, 1'h1, 8'h43);
    pin_chk(1'h1);
    wb(MODE, 1'h1, 8'hC1);
    high(h1, q1);
    wb(MODE, 1'h1, 8'hC3);
    high(h2, q2);
    `CHK("pwm_sum", 512, h1 + h2)
    `CHK("pwm_duty", 2 * (8'h40 + 1), h1)
    `CHK("pwm_irq", 0, q1 + q2)
    wb(MODE, 1'h1, 8'h41);
    pin_chk(1'h0);
    $display("pwm test done");
    test_done();
  end
endmodule
